// >>> rtl/ramp_seq_pkg.sv
// Purpose: Shared constants and types for the output ramp sequencer.
// Assumes: Setpoints are 12-bit codes of 2.5 mV; the step timer ticks every 10 us.
// Notes:   Register offsets and reset values live here and nowhere else.
`default_nettype none

package ramp_seq_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_RAMP_RATE = 8'h03;
	localparam logic [7:0] ADDR_STARTUP   = 8'h05;
	localparam logic [7:0] ADDR_SHUTDOWN  = 8'h06;

	localparam logic [6:0] RST_RAMP_RATE  = 7'h1c;
	localparam logic [7:0] RST_STARTUP    = 8'h00;
	localparam logic [5:0] RST_SHUTDOWN   = 6'h0b;

	// Field positions inside the ramp rate register.
	localparam int RISE_MSB    = 6;
	localparam int RISE_LSB    = 4;
	localparam int CTRL_EN_BIT = 3;
	localparam int FALL_MSB    = 2;
	localparam int FALL_LSB    = 0;

	// ---------------------------------------------------------------
	// Timing and stepping
	// ---------------------------------------------------------------
	localparam int              SP_W          = 12;
	localparam int              TMR_W         = 16;
	localparam logic [SP_W-1:0] STEP_CODES    = 12'h004;
	localparam int              TICK_US       = 10;
	localparam int              MS_US         = 1000;
	localparam logic [6:0]      TICKS_PER_MS  = 7'(MS_US / TICK_US);
	localparam int              MCLK_PER_TICK = 10;

	// Dwell per 10 mV step in ticks of 10 us, from the slew rate code.
	localparam logic [4:0] DWELL_0P05 = 5'h14;
	localparam logic [4:0] DWELL_0P1  = 5'h0a;
	localparam logic [4:0] DWELL_0P2  = 5'h05;
	localparam logic [4:0] DWELL_0P5  = 5'h02;
	localparam logic [4:0] DWELL_1P0  = 5'h01;

	typedef enum logic [5:0] {
		S_IDLE      = 6'h01,
		S_ON_DELAY  = 6'h02,
		S_RAMP_UP   = 6'h04,
		S_ON        = 6'h08,
		S_OFF_WAIT  = 6'h10,
		S_RAMP_DOWN = 6'h20
	} seq_state_e;

endpackage : ramp_seq_pkg

`default_nettype wire

// >>> rtl/step_if.sv
// Purpose: Carrier between the sequencer and its step timer.
// Assumes: One clock domain; start is a one-cycle pulse.
// Notes:   The master clock pin passes through untouched; the timer synchronises it.
`default_nettype none

interface step_if;
	import ramp_seq_pkg::*;
	logic             mclk_pin;
	logic             start;
	logic [TMR_W-1:0] load;
	logic             expired;
	logic             tick;

	modport ctrl  (output mclk_pin, output start, output load, input expired, input tick);
	modport timer (input mclk_pin, input start, input load, output expired, output tick);
endinterface : step_if

`default_nettype wire

// >>> rtl/step_timer.sv
// Purpose: Divides the external master clock into 10 us ticks and times delays.
// Assumes: Master clock is far slower than the system clock.
// Notes:   A load of zero expires after one tick, never at once.
`default_nettype none

module step_timer
	import ramp_seq_pkg::*;
#(
	parameter int DIV = MCLK_PER_TICK
) (
	input  wire logic sys_clk,
	input  wire logic srst,
	step_if.timer     tif
);

	typedef struct packed {
		logic [2:0]       sync;
		logic             filt;
		logic [7:0]       pre;
		logic [TMR_W-1:0] cnt;
		logic             running;
		logic             tick;
		logic             expired;
	} tmr_s;

	tmr_s st_r;
	tmr_s st_nxt;
	logic rise;

	// ---------------------------------------------------------------
	// Master clock divider and delay counter
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt         = st_r;
		st_nxt.tick    = 1'b0;
		st_nxt.expired = 1'b0;
		st_nxt.sync    = {st_r.sync[1:0], tif.mclk_pin};
		// Only stages two and three are compared; stage one is metastable-prone.
		rise = (st_r.sync[1] == st_r.sync[2]) && st_r.sync[2] && !st_r.filt;
		if (st_r.sync[1] == st_r.sync[2]) begin
			st_nxt.filt = st_r.sync[2];
		end
		if (rise) begin // R10
			if (st_r.pre == 8'(DIV - 1)) begin
				st_nxt.pre  = 8'h00;
				st_nxt.tick = 1'b1;
			end else begin
				st_nxt.pre = st_r.pre + 8'h01;
			end
		end
		if (tif.start) begin
			st_nxt.cnt     = tif.load;
			st_nxt.running = 1'b1;
		end else if (st_r.running && st_r.tick) begin
			if (st_r.cnt <= 16'h0001) begin
				st_nxt.running = 1'b0;
				st_nxt.expired = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tif.tick    = st_r.tick;
	assign tif.expired = st_r.expired;

	property p_tick_from_mclk;
		@(posedge sys_clk) disable iff (srst)
		st_r.tick |-> $past(rise) && $past(st_r.pre) == 8'(DIV - 1);
	endproperty
	a_tick_from_mclk: assert property (p_tick_from_mclk) // R10
		else $error("Step tick not derived from the master clock.");

endmodule : step_timer

`default_nettype wire

// >>> rtl/output_ramp_sequencer.sv
// Purpose: Turn-on/turn-off sequencing and setpoint ramping for a step-down converter.
// Assumes: VOUT_SENSE and TARGET_SETPOINT are synchronous 12-bit codes of 2.5 mV.
// Notes:   RUN_CMD, OC_DETECT and MASTER_CLK are pins and pass three flip-flops.
//
// How it works
// [R01] After turn-on, wait the programmed start delay, then begin ramping up.
// [R02] Slewed turn-off delay runs from command until output reaches zero.
// [R03] Slewed turn-off waits delay minus ramp-down time, then ramps down.
// [R04] Software must program an off delay longer than the ramp-down time.
// [R05] Without slew control, switches turn off when the off delay expires.
// [R06] Off delay is six bits in milliseconds; top bits read zero; resets to 11.
// [R07] Rising rate code in bits 6:4 picks 0.05 to 1.0 V/ms; resets to 1.
// [R08] Falling rate code in bits 2:0; bit 3 enables slew control, reset on.
// [R09] Ramps move the setpoint in 10 mV steps with rate-dependent dwell.
// [R10] Step dwell comes from dividing the externally supplied master clock.
// [R11] Overcurrent during a rising ramp trips protection and aborts turn-on.
// [R12] Software picks rise rate and limit so charging stays under the limit.
// [R13] Into a pre-biased output, the stage stays off until setpoint passes it.
// [R14] Software programs delays and rates through the three registers.
// [R15] Start delay is eight bits, resets to zero; zero ramps immediately.
// [R16] Stepping stops at the target or zero without overshooting.
`default_nettype none

module output_ramp_sequencer
	import ramp_seq_pkg::*;
#(
	parameter int MCLK_DIV = MCLK_PER_TICK
) (
	input  wire logic            SYS_CLK,
	input  wire logic            SRST,
	input  wire logic            MASTER_CLK,
	input  wire logic            RUN_CMD,
	input  wire logic            OC_DETECT,
	input  wire logic [SP_W-1:0] TARGET_SETPOINT,
	input  wire logic [SP_W-1:0] VOUT_SENSE,
	input  wire logic [7:0]      REG_ADDR,
	input  wire logic [7:0]      REG_WDATA,
	input  wire logic            REG_WR,
	output logic      [7:0]      REG_RDATA,
	output logic      [SP_W-1:0] SETPOINT,
	output logic                 PWM_EN,
	output logic                 OC_TRIP,
	output logic                 RAMP_BUSY
);

	typedef struct packed {
		seq_state_e      state;
		logic [6:0]      ramp_rate_config;
		logic [7:0]      startup_delay;
		logic [5:0]      shutdown_delay;
		logic [2:0]      run_sync;
		logic            run_f;
		logic [2:0]      oc_sync;
		logic            oc_f;
		logic            slew_off;
		logic [SP_W-1:0] sp;
		logic            pwm;
		logic            oc_trip;
		logic [7:0]      rdata;
	} seq_s;

	seq_s             st_r;
	seq_s             st_nxt;
	logic             start_c;
	logic [TMR_W-1:0] load_c;
	logic             on_evt;
	logic             off_evt;
	logic             ctrl_en;
	logic [4:0]       rise_dwell;
	logic [4:0]       fall_dwell;
	logic [10:0]      steps_left;
	logic [TMR_W-1:0] ramp_ticks;
	logic [TMR_W-1:0] off_ticks;

	step_if tif ();

	step_timer #(
		.DIV (MCLK_DIV)
	) u_timer (
		.sys_clk (SYS_CLK),
		.srst    (SRST),
		.tif     (tif.timer)
	);

	assign tif.mclk_pin = MASTER_CLK;
	assign tif.start    = start_c;
	assign tif.load     = load_c;

	// Codes 3, 6 and 7 have no defined rate; they fall back to 0.1 V/ms.
	function automatic logic [4:0] dwell_of(input logic [2:0] code);
		case (code)
			3'h0:    dwell_of = DWELL_0P05;
			3'h1:    dwell_of = DWELL_0P1;
			3'h2:    dwell_of = DWELL_0P2;
			3'h4:    dwell_of = DWELL_0P5;
			3'h5:    dwell_of = DWELL_1P0;
			default: dwell_of = DWELL_0P1;
		endcase
	endfunction : dwell_of

	// ---------------------------------------------------------------
	// Derived timing
	// ---------------------------------------------------------------
	always_comb begin
		ctrl_en    = st_r.ramp_rate_config[CTRL_EN_BIT];
		rise_dwell = dwell_of(st_r.ramp_rate_config[RISE_MSB:RISE_LSB]); // R07 R09
		fall_dwell = dwell_of(st_r.ramp_rate_config[FALL_MSB:FALL_LSB]); // R08 R09
		steps_left = 11'((13'(st_r.sp) + 13'h0003) >> 2);
		ramp_ticks = TMR_W'(steps_left * fall_dwell);
		off_ticks  = TMR_W'(st_r.shutdown_delay * TICKS_PER_MS);
		on_evt     = (st_r.run_sync[1] == st_r.run_sync[2]) && st_r.run_sync[2] && !st_r.run_f;
		off_evt    = (st_r.run_sync[1] == st_r.run_sync[2]) && !st_r.run_sync[2] && st_r.run_f;
	end

	// ---------------------------------------------------------------
	// Registers, synchronisers and sequencing
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt   = st_r;
		start_c  = 1'b0;
		load_c   = '0;
		st_nxt.run_sync = {st_r.run_sync[1:0], RUN_CMD};
		st_nxt.oc_sync  = {st_r.oc_sync[1:0], OC_DETECT};
		if (st_r.run_sync[1] == st_r.run_sync[2]) begin
			st_nxt.run_f = st_r.run_sync[2];
		end
		if (st_r.oc_sync[1] == st_r.oc_sync[2]) begin
			st_nxt.oc_f = st_r.oc_sync[2];
		end

		if (REG_WR) begin
			case (REG_ADDR)
				ADDR_RAMP_RATE: st_nxt.ramp_rate_config = REG_WDATA[6:0]; // R07 R08
				ADDR_STARTUP:   st_nxt.startup_delay    = REG_WDATA; // R15
				ADDR_SHUTDOWN:  st_nxt.shutdown_delay   = REG_WDATA[5:0]; // R06
				default:        st_nxt.shutdown_delay   = st_r.shutdown_delay;
			endcase
		end
		case (REG_ADDR)
			ADDR_RAMP_RATE: st_nxt.rdata = {1'b0, st_r.ramp_rate_config};
			ADDR_STARTUP:   st_nxt.rdata = st_r.startup_delay;
			ADDR_SHUTDOWN:  st_nxt.rdata = {2'b00, st_r.shutdown_delay}; // R06
			default:        st_nxt.rdata = 8'h00;
		endcase

		case (st_r.state)
			S_IDLE: begin
				st_nxt.sp  = '0;
				st_nxt.pwm = 1'b0;
				if (on_evt) begin
					st_nxt.oc_trip = 1'b0;
					if (st_r.startup_delay != 8'h00) begin // R01
						start_c      = 1'b1;
						load_c       = TMR_W'(st_r.startup_delay * TICKS_PER_MS);
						st_nxt.state = S_ON_DELAY;
					end else if (ctrl_en) begin // R15
						start_c      = 1'b1;
						load_c       = TMR_W'(rise_dwell);
						st_nxt.state = S_RAMP_UP;
					end else begin
						st_nxt.sp    = TARGET_SETPOINT;
						st_nxt.state = S_ON;
					end
				end
			end
			S_ON_DELAY: begin
				if (off_evt) begin
					st_nxt.state = S_IDLE;
				end else if (tif.expired) begin // R01
					if (ctrl_en) begin
						start_c      = 1'b1;
						load_c       = TMR_W'(rise_dwell);
						st_nxt.state = S_RAMP_UP;
					end else begin
						st_nxt.sp    = TARGET_SETPOINT;
						st_nxt.state = S_ON;
					end
				end
			end
			S_RAMP_UP: begin
				if (st_r.oc_f) begin // R11
					st_nxt.oc_trip = 1'b1;
					st_nxt.pwm     = 1'b0;
					st_nxt.sp      = '0;
					st_nxt.state   = S_IDLE;
				end else if (tif.expired) begin
					// Clamp the last step so the target is never overshot.
					if (13'(st_r.sp) + 13'(STEP_CODES) >= 13'(TARGET_SETPOINT)) begin // R16
						st_nxt.sp    = TARGET_SETPOINT;
						st_nxt.state = S_ON;
					end else begin
						st_nxt.sp = st_r.sp + STEP_CODES; // R09
						start_c   = 1'b1;
						load_c    = TMR_W'(rise_dwell);
					end
				end
			end
			S_ON: begin
				st_nxt.sp = TARGET_SETPOINT;
			end
			S_OFF_WAIT: begin
				if (tif.expired) begin
					if (st_r.slew_off) begin // R03
						start_c      = 1'b1;
						load_c       = TMR_W'(fall_dwell);
						st_nxt.state = S_RAMP_DOWN;
					end else begin // R05
						st_nxt.pwm   = 1'b0;
						st_nxt.sp    = '0;
						st_nxt.state = S_IDLE;
					end
				end
			end
			S_RAMP_DOWN: begin
				if (tif.expired) begin
					if (st_r.sp <= STEP_CODES) begin // R16 R02
						st_nxt.sp    = '0;
						st_nxt.pwm   = 1'b0;
						st_nxt.state = S_IDLE;
					end else begin
						st_nxt.sp = st_r.sp - STEP_CODES; // R09
						start_c   = 1'b1;
						load_c    = TMR_W'(fall_dwell);
					end
				end
			end
			default: begin
				st_nxt.state = S_IDLE;
			end
		endcase

		// Turn-off is taken from ramp-up and on; the slew choice is frozen here.
		if (off_evt && (st_r.state == S_RAMP_UP || st_r.state == S_ON)) begin
			st_nxt.slew_off = ctrl_en;
			start_c         = 1'b1;
			if (!ctrl_en) begin // R05
				load_c       = off_ticks;
				st_nxt.state = S_OFF_WAIT;
			end else if (off_ticks > ramp_ticks) begin // R03 R02
				load_c       = off_ticks - ramp_ticks;
				st_nxt.state = S_OFF_WAIT;
			end else begin
				// A too-short delay just starts the ramp down at once.
				load_c       = TMR_W'(fall_dwell);
				st_nxt.state = S_RAMP_DOWN;
			end
		end

		// The stage waits until the ramping target passes the output already present.
		if (st_nxt.state != S_IDLE && !st_r.pwm && st_nxt.sp > VOUT_SENSE) begin // R13
			st_nxt.pwm = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			st_r                  <= '0;
			st_r.state            <= S_IDLE;
			st_r.ramp_rate_config <= RST_RAMP_RATE;
			st_r.startup_delay    <= RST_STARTUP;
			st_r.shutdown_delay   <= RST_SHUTDOWN;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign REG_RDATA = st_r.rdata;
	assign SETPOINT  = st_r.sp;
	assign PWM_EN    = st_r.pwm;
	assign OC_TRIP   = st_r.oc_trip;
	assign RAMP_BUSY = st_r.state != S_IDLE && st_r.state != S_ON;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_delay_done;
		st_r.state == S_ON_DELAY && tif.expired && !off_evt && ctrl_en;
	endsequence

	sequence s_up_step;
		st_r.state == S_RAMP_UP && tif.expired && !st_r.oc_f && !off_evt;
	endsequence

	property p_ramp_after_delay;
		@(posedge SYS_CLK) disable iff (SRST)
		st_r.state == S_ON_DELAY ##1 st_r.state == S_RAMP_UP |-> $past(tif.expired);
	endproperty
	a_ramp_after_delay: assert property (p_ramp_after_delay) // R01
		else $error("Ramp started before the turn-on delay ran out.");

	property p_delay_then_ramp;
		@(posedge SYS_CLK) disable iff (SRST)
		s_delay_done |=> st_r.state == S_RAMP_UP && st_r.sp == '0;
	endproperty
	a_delay_then_ramp: assert property (p_delay_then_ramp) // R01
		else $error("Turn-on delay expiry did not start the ramp.");

	property p_zero_delay;
		@(posedge SYS_CLK) disable iff (SRST)
		st_r.state == S_IDLE && on_evt && st_r.startup_delay == 8'h00 && ctrl_en
			|=> st_r.state == S_RAMP_UP;
	endproperty
	a_zero_delay: assert property (p_zero_delay) // R15
		else $error("Zero turn-on delay did not ramp at once.");

	property p_step_size;
		@(posedge SYS_CLK) disable iff (SRST)
		s_up_step ##1 st_r.state == S_RAMP_UP |-> st_r.sp == $past(st_r.sp) + STEP_CODES;
	endproperty
	a_step_size: assert property (p_step_size) // R09
		else $error("Rising step is not 10 mV.");

	property p_no_overshoot;
		@(posedge SYS_CLK) disable iff (SRST)
		st_r.state == S_RAMP_UP |-> st_r.sp <= TARGET_SETPOINT;
	endproperty
	a_no_overshoot: assert property (p_no_overshoot) // R16
		else $error("Rising setpoint passed the target.");

	property p_prebias_hold;
		@(posedge SYS_CLK) disable iff (SRST)
		$rose(st_r.pwm) |-> st_r.sp > $past(VOUT_SENSE);
	endproperty
	a_prebias_hold: assert property (p_prebias_hold) // R13
		else $error("Power stage enabled below the pre-bias level.");

	property p_hard_off;
		@(posedge SYS_CLK) disable iff (SRST)
		st_r.state == S_OFF_WAIT && !st_r.slew_off && tif.expired
			|=> !st_r.pwm && st_r.state == S_IDLE;
	endproperty
	a_hard_off: assert property (p_hard_off) // R05
		else $error("Switches not turned off at turn-off delay expiry.");

	property p_down_wait;
		@(posedge SYS_CLK) disable iff (SRST)
		(st_r.state == S_ON) && off_evt && ctrl_en && off_ticks > ramp_ticks
			|-> start_c && load_c == off_ticks - ramp_ticks ##1 st_r.state == S_OFF_WAIT;
	endproperty
	a_down_wait: assert property (p_down_wait) // R03
		else $error("Internal wait before ramp-down is wrong.");

	property p_oc_trip;
		@(posedge SYS_CLK) disable iff (SRST)
		st_r.state == S_RAMP_UP && st_r.oc_f |=> OC_TRIP && !PWM_EN && st_r.state == S_IDLE;
	endproperty
	a_oc_trip: assert property (p_oc_trip) // R11
		else $error("Overcurrent during ramp-up did not trip.");

	property p_off_reserved;
		@(posedge SYS_CLK) disable iff (SRST)
		REG_ADDR == ADDR_SHUTDOWN |=> REG_RDATA[7:6] == 2'b00
			&& REG_RDATA[5:0] == $past(st_r.shutdown_delay);
	endproperty
	a_off_reserved: assert property (p_off_reserved) // R06
		else $error("Turn-off delay readback is wrong.");

endmodule : output_ramp_sequencer

`default_nettype wire

// >>> tb/power_manager_model.sv
// Purpose: Stand-in for the external power manager that feeds the sequencer.
// Assumes: System clock of 100 ns; the master clock toggles every HALF system cycles.
// Notes:   The master clock runs free; the run command is a level set by the bench.
`default_nettype none

module power_manager_model #(
	parameter int HALF = 5
) (
	input  wire logic SYS_CLK,
	output logic      MASTER_CLK,
	output logic      RUN_CMD
);
	timeunit 1ns;
	timeprecision 1ns;

	// The command level starts low so that no turn-on edge follows reset.
	logic run_lvl = 1'b0;

	assign RUN_CMD = run_lvl;

	// One common clock for every converter keeps their ramps matched.
	initial begin
		MASTER_CLK = 1'b0;
		forever begin
			repeat (HALF) @(posedge SYS_CLK);
			MASTER_CLK <= ~MASTER_CLK;
		end
	end

	task automatic command(input logic on);
		@(posedge SYS_CLK);
		run_lvl <= on;
	endtask : command
endmodule : power_manager_model

`default_nettype wire

// >>> tb/output_ramp_sequencer_tb.sv
// Purpose: Self-checking bench for the output ramp sequencer.
// Assumes: Master clock period is ten system cycles and MCLK_DIV is 1, so a tick is 1 us.
// Notes:   Delay windows allow for the pin synchronisers and the tick phase.
`default_nettype none

module output_ramp_sequencer_tb
	import ramp_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic            sys_clk;
	logic            srst;
	logic            oc;
	logic            reg_wr;
	logic            master_clk;
	logic            run_cmd;
	logic            pwm_en;
	logic            oc_trip;
	logic            ramp_busy;
	logic [SP_W-1:0] tgt;
	logic [SP_W-1:0] vout;
	logic [SP_W-1:0] setpoint;
	logic [7:0]      reg_addr;
	logic [7:0]      reg_wdata;
	logic [7:0]      reg_rdata;
	int              n_errors = 0;
	int              tests_run = 0;

	power_manager_model pm (
		.SYS_CLK    (sys_clk),
		.MASTER_CLK (master_clk),
		.RUN_CMD    (run_cmd)
	);

	output_ramp_sequencer #(
		.MCLK_DIV (1)
	) uut (
		.SYS_CLK         (sys_clk),
		.SRST            (srst),
		.MASTER_CLK      (master_clk),
		.RUN_CMD         (run_cmd),
		.OC_DETECT       (oc),
		.TARGET_SETPOINT (tgt),
		.VOUT_SENSE      (vout),
		.REG_ADDR        (reg_addr),
		.REG_WDATA       (reg_wdata),
		.REG_WR          (reg_wr),
		.REG_RDATA       (reg_rdata),
		.SETPOINT        (setpoint),
		.PWM_EN          (pwm_en),
		.OC_TRIP         (oc_trip),
		.RAMP_BUSY       (ramp_busy)
	);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_rng(input int got, input int lo, input int hi);
		tests_run++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask : chk_rng

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask : reg_write

	task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		repeat (2) @(posedge sys_clk);
		#1 chk_val(16'(reg_rdata), 16'(exp));
	endtask : reg_check

	// Counts cycles until the setpoint moves, sampling after each edge has landed.
	task automatic wait_chg(input int limit, output int n);
		logic [SP_W-1:0] prev;
		prev = setpoint;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (setpoint === prev && n < limit);
	endtask : wait_chg

	task automatic ramp_up(input int dwell);
		int              n;
		logic [SP_W-1:0] exp;
		exp = '0;
		while (exp != tgt && n < 4000) begin
			wait_chg(4000, n);
			if (exp == 0) chk_rng(n, 1, dwell * 10 + 15);
			else chk_val(16'(n), 16'(dwell * 10 - 1));
			exp = (tgt - exp > STEP_CODES) ? exp + STEP_CODES : tgt;
			chk_val(16'(setpoint), 16'(exp));
			@(posedge sys_clk);
			#1 chk_val(16'(pwm_en), 16'(setpoint > vout));
		end
		repeat (3) @(posedge sys_clk);
		#1 chk_val(16'(ramp_busy), 16'h0);
		chk_val(16'(setpoint), 16'(tgt));
	endtask : ramp_up

	task automatic turn_off_quick();
		reg_write(ADDR_SHUTDOWN, 8'h00);
		reg_write(ADDR_RAMP_RATE, 8'h10);
		pm.command(1'b0);
		repeat (40) @(posedge sys_clk);
		#1 chk_val(16'({setpoint, pwm_en, ramp_busy}), 16'h0);
	endtask : turn_off_quick

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		reg_check(ADDR_RAMP_RATE, 8'h1c);
		reg_check(ADDR_STARTUP, 8'h00);
		reg_check(ADDR_SHUTDOWN, 8'h0b);
		reg_write(ADDR_SHUTDOWN, 8'hff);
		reg_write(8'h04, 8'hff);
		reg_write(ADDR_RAMP_RATE, 8'hff);
		reg_write(ADDR_STARTUP, 8'ha5);
		reg_check(ADDR_SHUTDOWN, 8'h3f);
		reg_check(8'h04, 8'h00);
		reg_check(ADDR_RAMP_RATE, 8'h7f);
		reg_check(ADDR_STARTUP, 8'ha5);
		reg_write(ADDR_STARTUP, 8'h00);
	endtask : t_regs

	task automatic t_rates();
		int dw [5] = '{20, 10, 5, 2, 1};
		for (int i = 0; i < 5; i++) begin
			reg_write(ADDR_RAMP_RATE, {1'b0, 3'((i < 3) ? i : i + 1), 4'h8});
			vout <= (i == 0) ? 12'h00e : 12'h000;
			pm.command(1'b1);
			ramp_up(dw[i]);
			turn_off_quick();
		end
		vout <= 12'h000;
	endtask : t_rates

	task automatic t_start_delay();
		int n;
		reg_write(ADDR_STARTUP, 8'h01);
		reg_write(ADDR_RAMP_RATE, 8'h50);
		pm.command(1'b1);
		wait_chg(1200, n);
		chk_rng(n, 990, 1030);
		repeat (120) @(posedge sys_clk);
		#1 chk_val(16'(setpoint), 16'(tgt));
		tgt <= 12'h030;
		repeat (2) @(posedge sys_clk);
		#1 chk_val(16'(setpoint), 16'h030);
		turn_off_quick();
		reg_write(ADDR_STARTUP, 8'h00);
	endtask : t_start_delay

	// Off delay of 1 ms leaves a positive wait before an 8-step ramp-down.
	task automatic t_slew_off();
		int              n;
		int              total;
		logic [SP_W-1:0] exp;
		tgt <= 12'h020;
		reg_write(ADDR_SHUTDOWN, 8'h01);
		reg_write(ADDR_RAMP_RATE, 8'h5a);
		pm.command(1'b1);
		ramp_up(1);
		pm.command(1'b0);
		total = 0;
		exp = 12'h020;
		while (exp != 0 && total < 3000) begin
			wait_chg(1200, n);
			if (exp == 12'h020) chk_rng(n, 640, 665);
			else chk_val(16'(n), 16'd50);
			total += n;
			exp -= STEP_CODES;
			chk_val(16'(setpoint), 16'(exp));
		end
		chk_rng(total, 980, 1020);
		repeat (3) @(posedge sys_clk);
		#1 chk_val(16'(pwm_en), 16'h0);
	endtask : t_slew_off

	task automatic t_hard_off();
		int n;
		reg_write(ADDR_SHUTDOWN, 8'h02);
		reg_write(ADDR_RAMP_RATE, 8'h5a);
		pm.command(1'b1);
		ramp_up(1);
		// Slew control is dropped only now; the choice is taken at the turn-off command.
		reg_write(ADDR_RAMP_RATE, 8'h52);
		pm.command(1'b0);
		wait_chg(2500, n);
		chk_rng(n, 1980, 2030);
		repeat (2) @(posedge sys_clk);
		#1 chk_val(16'({setpoint, pwm_en}), 16'h0);
	endtask : t_hard_off

	task automatic t_overcurrent();
		int n;
		tgt <= 12'h022;
		reg_write(ADDR_RAMP_RATE, 8'h08);
		pm.command(1'b1);
		repeat (2) wait_chg(400, n);
		oc <= 1'b1;
		repeat (8) @(posedge sys_clk);
		#1 chk_val(16'({oc_trip, pwm_en, ramp_busy}), 16'h4);
		chk_val(16'(setpoint), 16'h0);
		@(posedge sys_clk);
		oc <= 1'b0;
		pm.command(1'b0);
		repeat (10) @(posedge sys_clk);
		pm.command(1'b1);
		repeat (10) @(posedge sys_clk);
		#1 chk_val(16'(oc_trip), 16'h0);
		turn_off_quick();
	endtask : t_overcurrent

	// ---------------------------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		srst      = 1'b1;
		oc        = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		tgt       = 12'h022;
		vout      = 12'h000;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		t_regs();
		t_rates();
		t_start_delay();
		t_slew_off();
		t_hard_off();
		t_overcurrent();
		summarize();
	end

	// All scenarios need about 9000 cycles; this leaves ample margin.
	initial begin
		repeat (40000) @(posedge sys_clk);
		n_errors++;
		$display("watchdog expired at %0t", $time);
		summarize();
	end
endmodule : output_ramp_sequencer_tb

`default_nettype wire
